// File: core/twp_pkg.sv
/*
  constants, register map and state encodings of the two-wire port.
  assumes one 200 MHz system clock shared by the whole port.
*/
package twp_pkg;
  localparam int IDX_LSB = 2;
  localparam logic [7:0] IDX_DIV = 8'h00;
  localparam logic [7:0] IDX_ID = 8'h01;
  localparam logic [7:0] IDX_STAT = 8'h02;
  localparam logic [7:0] IDX_CTL = 8'h03;
  localparam logic [7:0] IDX_BUF1 = 8'h04;
  localparam logic [7:0] IDX_BUF2 = 8'h05;
  localparam logic [7:0] IDX_BUF3 = 8'h06;
  localparam logic [7:0] IDX_SEQ = 8'h07;
  localparam logic [7:0] IDX_MOFF = 8'he0;
  localparam logic [7:0] IDX_MBL = 8'he1;
  localparam logic [7:0] IDX_MBM = 8'he2;
  localparam logic [7:0] IDX_MBH = 8'he3;
  localparam logic [7:0] IDX_HOST = 8'he4;
  localparam logic [7:0] RST_DIV = 8'h1f;
  localparam logic [7:0] RST_ID = 8'h5c;
  localparam logic [7:0] RST_CTL = 8'h01;
  localparam logic [7:0] RST_BUF1 = 8'h5a;
  localparam logic [7:0] RST_BUF2 = 8'hf1;
  localparam logic [7:0] RST_MBL = 8'h80;
  localparam logic [7:0] RST_MBM = 8'hd7;
  localparam logic [7:0] RST_ZERO = 8'h00;
  localparam int CTL_INC = 0;
  localparam int CTL_MST = 1;
  localparam int CTL_MAP = 2;
  localparam int CTL_STR = 3;
  localparam int SEQ_ID = 0;
  localparam int SEQ_FIRST = 1;
  localparam int SEQ_WR = 2;
  localparam int SEQ_RD = 3;
  localparam int SEQ_START = 4;
  localparam int SEQ_STOP = 5;
  localparam int SEQ_RDID = 6;
  localparam int SEQ_ACK = 7;
  localparam int HF_ACC = 0;
  localparam int HF_RD = 1;
  localparam int P_START = 0;
  localparam int P_ID = 1;
  localparam int P_FIRST = 2;
  localparam int P_WR = 3;
  localparam int P_RD = 4;
  localparam int P_STOP = 5;
  localparam logic [23:0] DIRECT_OFS = 24'h80_0000;
  localparam logic [3:0] BYTE_BITS = 4'h8;
  localparam logic [2:0] LAST_BIT = 3'h7;
  localparam logic [1:0] ADDR_BYTES = 2'h3;
  localparam logic [1:0] Q_PRE = 2'h0;
  localparam logic [1:0] Q_SET = 2'h1;
  localparam logic [1:0] Q_HI = 2'h2;
  localparam logic [1:0] Q_END = 2'h3;
  localparam int SYS_CLK_HZ = 200_000_000;
  localparam int RATE_STD_BPS = 100_000;
  localparam int RATE_FAST_BPS = 400_000;
  localparam int MIN_CLK_RATIO = 10;
  localparam int QUARTERS = 4;
  localparam int DIV_FAST = SYS_CLK_HZ / (QUARTERS * RATE_FAST_BPS);
  typedef enum logic [6:0] {
    M_IDLE = 7'b000_0001, M_START = 7'b000_0010, M_TXB = 7'b000_0100, M_RXACK = 7'b000_1000,
    M_RXB = 7'b001_0000, M_TXACK = 7'b010_0000, M_STOP = 7'b100_0000
  } twp_mst_t;
  typedef enum logic [6:0] {
    T_IDLE = 7'b000_0001, T_ADDR = 7'b000_0010, T_AACK = 7'b000_0100, T_RX = 7'b000_1000,
    T_RACK = 7'b001_0000, T_TX = 7'b010_0000, T_TACK = 7'b100_0000
  } twp_tgt_t;
endpackage : twp_pkg

// File: core/twp_port.sv
/*
  two-wire port: initiator sequence engine, target with direct and mapped
  memory access, apb register slave.
  assumes open-drain pads resolved outside, memory answering mem_rd with
  mem_rdata valid from the next cycle, clock at least ten times the bit rate.
*/
// The APB slave port is this design's own decision.
// Behaviour
// - supports 100 and 400 kbit/s rates
// - both lines released when bus idle
// - sda changes only while scl low, except in start and stop
// - only initiator starts and clocks transfers
// - clock speed register resets to 0x1f
// - seven-bit address in bits 7..1
// - status busy, packet busy, last ack
// - control bit 0 auto increment, on
// - control bit 1 selects initiator role
// - control bit 2 selects mapped submode
// - stretch holds scl low, resumes high
// - three initiator byte buffers
// - sequence bits launch phases in order
// - sequence bit 3 adds third write byte
// - bit 6 read direction, bit 7 ack
// - last mapped offset readable
// - mapped base from three bytes
// - host flags access and read, w1c
// - target role out of reset
// - target acknowledges automatically
// - scl equals clock over four times divider times PRESCALE
// - busy per phase, packet start to stop
// - mapped halves restart after stop
// - direct address offset by 0x800000
`timescale 1ns/10ps
module twp_port
  import twp_pkg::*;
#(
  parameter int AW = 12,
  parameter int PRESCALE = 1
)
(
  input wire logic clock,
  input wire logic rst_b,
  input wire logic ce,
  input wire logic psel,
  input wire logic penable,
  input wire logic pwrite,
  input wire logic [AW-1:0] paddr,
  input wire logic [31:0] pwdata,
  output logic [31:0] prdata,
  output logic pready,
  output logic pslverr,
  input wire logic scl_i,
  output logic scl_o,
  output logic scl_oe_b,
  input wire logic sda_i,
  output logic sda_o,
  output logic sda_oe_b,
  output logic [23:0] mem_addr,
  output logic [7:0] mem_wdata,
  output logic mem_wr,
  output logic mem_rd,
  input wire logic [7:0] mem_rdata,
  input wire logic mem_ready
);
typedef struct packed {
  logic [7:0] div, id, ctl, buf1, buf2, buf3, seq, mbl, mbm, mbh;
  logic [6:0] moff, tlast;
  logic [1:0] host;
  logic busy, pkt, nak;
  logic [31:0] prdata;
  twp_mst_t ms;
  logic [7:0] qcnt, pre;
  logic [1:0] q;
  logic [2:0] bit_n;
  logic [7:0] msh;
  logic [5:0] pend, ph;
  logic w3, msda;
  twp_tgt_t ts;
  logic [7:0] tsh;
  logic [3:0] tbit;
  logic [1:0] tidx;
  logic trd, tnak, tsda, tscl;
  logic [23:0] tptr;
  logic [5:0] toff;
  logic scl0, scl1, sclp, sda0, sda1, sdap;
  logic scl_low, sda_low, mwr, mrd;
  logic [23:0] maddr;
  logic [7:0] mwd;
} twp_state_t;
twp_state_t s_r, s_nxt;
logic apb_wr;
logic [7:0] apb_idx;
//////////////////////////////////////////////////////////////////////////////
function automatic logic twp_known(input logic [7:0] i);
  twp_known = (i <= IDX_SEQ) || (i >= IDX_MOFF && i <= IDX_HOST);
endfunction : twp_known
function automatic logic [5:0] twp_lowest(input logic [5:0] p);
  twp_lowest = p & (~p + 6'h01);
endfunction : twp_lowest
function automatic logic [23:0] twp_maddr(input logic map, input logic rd, input logic [23:0] base,
                                           input logic [23:0] ptr, input logic [5:0] off);
  twp_maddr = map ? base + 24'({rd, off}) : DIRECT_OFS + ptr;
endfunction : twp_maddr
//////////////////////////////////////////////////////////////////////////////
assign apb_wr = psel && penable && pwrite;
assign apb_idx = paddr[IDX_LSB +: 8];
assign pready = 1'b1;
assign pslverr = psel && penable && !twp_known(apb_idx);
assign prdata = s_r.prdata;
assign scl_o = 1'b0;
assign sda_o = 1'b0;
assign scl_oe_b = !s_r.scl_low;
assign sda_oe_b = !s_r.sda_low;
assign mem_addr = s_r.maddr;
assign mem_wdata = s_r.mwd;
assign mem_wr = s_r.mwr;
assign mem_rd = s_r.mrd;
always_comb
begin : comb_p
  twp_state_t n;
  logic [7:0] rv, qdiv;
  logic [1:0] hset, hclr;
  logic adv, tick, stall, rise, fall, st_c, sp_c, tgt, map, bump, rdreq, mscl;
  logic [5:0] ph;
  n = s_r;
  rv = RST_ZERO;
  hset = 2'b00;
  hclr = 2'b00;
  adv = 1'b0;
  bump = 1'b0;
  rdreq = 1'b0;
  mscl = 1'b0;
  ph = 6'h00;
  qdiv = 8'h01;
  tick = 1'b0;
  stall = 1'b0;
  rise = 1'b0;
  fall = 1'b0;
  st_c = 1'b0;
  sp_c = 1'b0;
  tgt = 1'b0;
  map = 1'b0;
  n.mwr = 1'b0;
  n.mrd = 1'b0;
  n.scl0 = scl_i;
  n.scl1 = s_r.scl0;
  n.sclp = s_r.scl1;
  n.sda0 = sda_i;
  n.sda1 = s_r.sda0;
  n.sdap = s_r.sda1;
  // register slave
  if (psel && !penable && !pwrite)
  begin
    if (apb_idx == IDX_DIV) rv = s_r.div;
    else if (apb_idx == IDX_ID) rv = s_r.id;
    else if (apb_idx == IDX_STAT) rv = {5'h00, s_r.nak, s_r.pkt, s_r.busy};
    else if (apb_idx == IDX_CTL) rv = s_r.ctl;
    else if (apb_idx == IDX_BUF1) rv = s_r.buf1;
    else if (apb_idx == IDX_BUF2) rv = s_r.buf2;
    else if (apb_idx == IDX_BUF3) rv = s_r.buf3;
    else if (apb_idx == IDX_SEQ) rv = s_r.seq;
    else if (apb_idx == IDX_MOFF) rv = {1'b0, s_r.moff};
    else if (apb_idx == IDX_MBL) rv = s_r.mbl;
    else if (apb_idx == IDX_MBM) rv = s_r.mbm;
    else if (apb_idx == IDX_MBH) rv = s_r.mbh;
    else if (apb_idx == IDX_HOST) rv = {6'h00, s_r.host};
    n.prdata = {24'h00_0000, rv};
  end
  if (apb_wr)
  begin
    if (apb_idx == IDX_DIV) n.div = pwdata[7:0];
    else if (apb_idx == IDX_ID) n.id = pwdata[7:0];
    else if (apb_idx == IDX_CTL) n.ctl = pwdata[7:0];
    else if (apb_idx == IDX_BUF1) n.buf1 = pwdata[7:0];
    else if (apb_idx == IDX_BUF2) n.buf2 = pwdata[7:0];
    else if (apb_idx == IDX_BUF3) n.buf3 = pwdata[7:0];
    else if (apb_idx == IDX_MBL) n.mbl = pwdata[7:0];
    else if (apb_idx == IDX_MBM) n.mbm = pwdata[7:0];
    else if (apb_idx == IDX_MBH) n.mbh = pwdata[7:0];
    else if (apb_idx == IDX_HOST) hclr = pwdata[1:0];
    else if (apb_idx == IDX_SEQ)
    begin
      n.seq = pwdata[7:0];
      if (s_r.ctl[CTL_MST] && s_r.ms == M_IDLE)
      begin
        n.pend = {pwdata[SEQ_STOP], pwdata[SEQ_RD] & ~pwdata[SEQ_WR], pwdata[SEQ_WR],
                  pwdata[SEQ_FIRST], pwdata[SEQ_ID], pwdata[SEQ_START]};
        n.w3 = pwdata[SEQ_RD];
        adv = 1'b1;
      end
    end
  end
  //////////////////////////////////////////////////////////////////////////////
  // initiator: four quarters per bit, each div*PRESCALE clocks
  qdiv = (s_r.div == RST_ZERO) ? 8'h01 : s_r.div;
  stall = s_r.ms != M_IDLE && s_r.q == Q_HI && !s_r.scl1;
  tick = 1'b0;
  if (s_r.ms != M_IDLE && !stall)
  begin
    n.pre = (s_r.pre == 8'(PRESCALE - 1)) ? 8'h00 : s_r.pre + 8'h01;
    if (s_r.pre == 8'(PRESCALE - 1))
    begin
      tick = s_r.qcnt == qdiv - 8'h01;
      n.qcnt = tick ? 8'h00 : s_r.qcnt + 8'h01;
    end
  end
  if (tick)
  begin
    n.q = s_r.q + 2'h1;
    if (s_r.q == Q_END)
    begin
      case (s_r.ms)
        M_START:
        begin
          n.pkt = 1'b1;
          adv = 1'b1;
        end
        M_TXB:
        begin
          n.msh = {s_r.msh[6:0], 1'b0};
          n.bit_n = s_r.bit_n + 3'h1;
          if (s_r.bit_n == LAST_BIT) n.ms = M_RXACK;
        end
        M_RXACK:
        begin
          n.nak = s_r.scl1 ? s_r.sda1 : 1'b1;
          if (s_r.ph[P_WR] && s_r.w3)
          begin
            n.w3 = 1'b0;
            n.msh = s_r.buf3;
            n.ms = M_TXB;
          end
          else adv = 1'b1;
        end
        M_RXB:
        begin
          n.msh = {s_r.msh[6:0], s_r.sda1};
          n.bit_n = s_r.bit_n + 3'h1;
          if (s_r.bit_n == LAST_BIT)
          begin
            n.buf3 = {s_r.msh[6:0], s_r.sda1};
            n.ms = M_TXACK;
          end
        end
        M_TXACK: adv = 1'b1;
        M_STOP:
        begin
          n.pkt = 1'b0;
          adv = 1'b1;
        end
        default: ;
      endcase
    end
  end
  if (adv)
  begin
    ph = twp_lowest(n.pend);
    n.pend = n.pend & ~ph;
    n.ph = ph;
    n.bit_n = 3'h0;
    n.q = Q_PRE;
    n.qcnt = 8'h00;
    n.pre = 8'h00;
    n.msh = ph[P_ID] ? {n.id[7:1], n.seq[SEQ_RDID]} : (ph[P_FIRST] ? n.buf1 : n.buf2);
    if (ph[P_START]) n.ms = M_START;
    else if (ph[P_STOP]) n.ms = M_STOP;
    else if (ph[P_RD]) n.ms = M_RXB;
    else if (ph != 6'h00) n.ms = M_TXB;
    else n.ms = M_IDLE;
  end
  n.busy = n.ms != M_IDLE;
  // sda moves at the second low quarter, scl low; start and stop also move it in the last quarter, scl high
  case (n.ms)
    M_START:
    begin
      mscl = n.q < Q_HI && n.pkt;
      n.msda = (n.q == Q_PRE) ? s_r.msda : n.q == Q_END;
    end
    M_TXB, M_TXACK, M_RXACK, M_RXB:
    begin
      mscl = n.q < Q_HI;
      if (n.q == Q_SET) n.msda = n.ms == M_TXB ? !n.msh[7] : (n.ms == M_TXACK && n.seq[SEQ_ACK]);
    end
    M_STOP:
    begin
      mscl = n.q < Q_HI;
      n.msda = (n.q == Q_PRE) ? s_r.msda : n.q != Q_END;
    end
    default:
    begin
      mscl = n.pkt;
      if (!n.pkt) n.msda = 1'b0;
    end
  endcase
  //////////////////////////////////////////////////////////////////////////////
  // target: follows the other party's clock, acks without software
  tgt = !s_r.ctl[CTL_MST];
  map = s_r.ctl[CTL_MAP];
  rise = s_r.scl1 && !s_r.sclp;
  fall = !s_r.scl1 && s_r.sclp;
  st_c = s_r.scl1 && s_r.sclp && s_r.sdap && !s_r.sda1;
  sp_c = s_r.scl1 && s_r.sclp && !s_r.sdap && s_r.sda1;
  if (!tgt)
  begin
    n.ts = T_IDLE;
    n.tsda = 1'b0;
  end
  else if (sp_c)
  begin
    n.ts = T_IDLE;
    n.tsda = 1'b0;
    n.tidx = 2'h0;
    n.toff = 6'h00;
    n.moff = s_r.tlast;
  end
  else if (st_c)
  begin
    n.ts = T_ADDR;
    n.tbit = 4'h0;
    n.tsda = 1'b0;
  end
  else
  begin
    case (s_r.ts)
      T_ADDR, T_RX:
      begin
        if (rise)
        begin
          n.tsh = {s_r.tsh[6:0], s_r.sda1};
          n.tbit = s_r.tbit + 4'h1;
        end
        else if (fall && s_r.tbit == BYTE_BITS && s_r.ts == T_ADDR)
        begin
          if (s_r.tsh[7:1] == s_r.id[7:1])
          begin
            hset = {s_r.tsh[0], 1'b1};
            n.trd = s_r.tsh[0];
            n.tsda = 1'b1;
            n.ts = T_AACK;
            rdreq = s_r.tsh[0];
          end
          else n.ts = T_IDLE;
        end
        else if (fall && s_r.tbit == BYTE_BITS)
        begin
          n.tsda = 1'b1;
          n.ts = T_RACK;
          if (!map && s_r.tidx != ADDR_BYTES)
          begin
            n.tidx = s_r.tidx + 2'h1;
            n.tptr = {s_r.tptr[15:0], s_r.tsh};
          end
          else
          begin
            n.mwr = 1'b1;
            n.mwd = s_r.tsh;
            n.maddr = twp_maddr(map, 1'b0, {s_r.mbh, s_r.mbm, s_r.mbl}, s_r.tptr, s_r.toff);
            n.tlast = {1'b0, s_r.toff};
            bump = 1'b1;
          end
        end
      end
      T_AACK, T_TACK:
      begin
        if (rise && s_r.ts == T_TACK)
        begin
          n.tnak = s_r.sda1;
          bump = !s_r.sda1;
          rdreq = !s_r.sda1;
        end
        else if (fall && (s_r.ts == T_TACK ? !s_r.tnak : s_r.trd))
        begin
          n.ts = T_TX;
          n.tsh = mem_rdata;
          n.tbit = 4'h0;
          n.tsda = !mem_rdata[7];
        end
        else if (fall)
        begin
          n.ts = s_r.ts == T_TACK ? T_IDLE : T_RX;
          n.tbit = 4'h0;
          n.tsda = 1'b0;
        end
      end
      T_RACK:
      begin
        if (fall)
        begin
          n.ts = T_RX;
          n.tbit = 4'h0;
          n.tsda = 1'b0;
        end
      end
      T_TX:
      begin
        if (fall && s_r.tbit == 4'(LAST_BIT))
        begin
          n.ts = T_TACK;
          n.tsda = 1'b0;
        end
        else if (fall)
        begin
          n.tsh = {s_r.tsh[6:0], 1'b0};
          n.tbit = s_r.tbit + 4'h1;
          n.tsda = !s_r.tsh[6];
        end
      end
      default: ;
    endcase
  end
  if (bump && map) n.toff = n.toff + 6'h01;
  else if (bump && s_r.ctl[CTL_INC]) n.tptr = n.tptr + 24'h00_0001;
  if (rdreq)
  begin
    n.mrd = 1'b1;
    n.maddr = twp_maddr(map, 1'b1, {s_r.mbh, s_r.mbm, s_r.mbl}, n.tptr, n.toff);
    n.tlast = {1'b1, n.toff};
  end
  n.tscl = tgt && s_r.ctl[CTL_STR] && !mem_ready && s_r.ts != T_IDLE && (!s_r.scl1 || s_r.tscl);
  n.host = (s_r.host & ~hclr) | hset;
  n.scl_low = mscl || n.tscl;
  n.sda_low = n.msda || n.tsda;
  s_nxt = n;
end
always_ff @(posedge clock)
begin
  if (!rst_b)
  begin
    s_r <= '0;
    s_r.div <= RST_DIV;
    s_r.id <= RST_ID;
    s_r.ctl <= RST_CTL;
    s_r.buf1 <= RST_BUF1;
    s_r.buf2 <= RST_BUF2;
    s_r.mbl <= RST_MBL;
    s_r.mbm <= RST_MBM;
    s_r.ms <= M_IDLE;
    s_r.ts <= T_IDLE;
  end
  else if (ce)
    s_r <= s_nxt;
end
//////////////////////////////////////////////////////////////////////////////
default clocking cb @(posedge clock); endclocking
default disable iff (!rst_b || !ce);
sequence s_launch;
  apb_wr && apb_idx == IDX_SEQ && pwdata[SEQ_START] && s_r.ctl[CTL_MST] && s_r.ms == M_IDLE;
endsequence
sequence s_started;
  s_r.busy && s_r.ms == M_START;
endsequence
a_pins_low_only: assert property (!scl_o && !sda_o) else $error("line driven high");
a_idle_released: assert property ((s_r.ms == M_IDLE && !s_r.pkt && s_r.ts == T_IDLE && !s_r.tscl)
  |-> scl_oe_b && sda_oe_b) else $error("idle bus not released");
a_reset_target: assert property ($rose(rst_b) |-> !s_r.ctl[CTL_MST] && s_r.ctl == RST_CTL)
  else $error("not target after reset");
a_launch_start: assert property (s_launch |=> s_started) else $error("sequence did not start");
a_packet_end: assert property ($fell(s_r.pkt) |-> $past(s_r.ms) == M_STOP)
  else $error("packet busy cleared outside stop");
a_host_access: assert property ($rose(s_r.ts == T_AACK) |-> s_r.host[HF_ACC] && (s_r.host[HF_RD] || !s_r.trd))
  else $error("host flags not set");
a_host_clear: assert property ((apb_wr && apb_idx == IDX_HOST && pwdata[HF_ACC] && s_nxt.ts != T_AACK)
  |=> !s_r.host[HF_ACC]) else $error("host flag not cleared");
a_quarter_div: assert property (s_r.ms != M_IDLE |-> s_r.qcnt == 8'h00 || s_r.qcnt < s_r.div)
  else $error("quarter count beyond divider");
a_sda_stable: assert property ((s_r.ms == M_TXB && s_r.q >= Q_HI && $past(s_r.ms) == M_TXB && $past(s_r.q) >= Q_HI)
  |-> $stable(s_r.msda)) else $error("sda moved while scl high");
a_auto_ack: assert property ((s_r.ts == T_AACK || s_r.ts == T_RACK) |-> !sda_oe_b)
  else $error("target ack missing");
a_stretch_hold: assert property ((!s_r.ctl[CTL_MST] && s_r.ctl[CTL_STR] && !mem_ready && s_r.ts != T_IDLE
  && !s_r.scl1) |=> !scl_oe_b) else $error("stretch not held");
a_bad_offset: assert property ((psel && penable && !twp_known(apb_idx)) |-> pslverr)
  else $error("unmapped access without error");
endmodule : twp_port

// File: testbench/twp_target_model.sv
/*
  behavioural target on the two-wire bus, facing the port's initiator role.
  assumes open-drain lines whose pull-ups are resolved in the bench.
*/
`timescale 1ns/10ps
module twp_target_model
#(
  parameter logic [6:0] ID = 7'h2e
)
(
  input wire logic scl,
  input wire logic sda,
  input wire logic [7:0] rd_byte,
  output logic sda_rel
);
  logic [7:0] sh;
  logic [7:0] got [$];
  logic sel, rd, mack, act;
  int cnt, nb;
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    sda_rel = 1'b1;
    act = 1'b0;
  end
  // start and stop are the only sda edges while scl is high
  always @(negedge sda)
    if (scl === 1'b1)
    begin
      act = 1'b1;
      cnt = 0;
      nb = 0;
      sel = 1'b0;
      rd = 1'b0;
      mack = 1'b0;
    end
  always @(posedge sda)
    if (scl === 1'b1)
      act = 1'b0;
  always @(posedge scl)
    if (act)
    begin
      if (cnt < 8)
        sh = {sh[6:0], sda};
      else if (rd && nb > 0)
        mack = sda;
      cnt++;
    end
  // the model only drives sda after scl has fallen
  always @(negedge scl)
    if (act)
    begin
      if (cnt == 9)
      begin
        cnt = 0;
        nb++;
      end
      if (cnt == 8 && nb == 0)
      begin
        sel = (sh[7:1] == ID);
        rd = sh[0];
      end
      if (cnt == 8 && nb > 0 && sel && !rd)
        got.push_back(sh);
      if (cnt == 8)
        sda_rel = !(sel && (nb == 0 || !rd));
      else if (sel && rd && !mack && nb > 0)
        sda_rel = rd_byte[3'(7 - cnt)];
      else
        sda_rel = 1'b1;
    end
endmodule : twp_target_model

// File: testbench/tb.sv
/*
  self-checking bench of the two-wire port: apb registers, initiator transfers
  against the target model, target accesses from a bench initiator.
  assumes a 200 MHz clock and pull-ups on both lines.
*/
`timescale 1ns/10ps
module tb;
  import twp_pkg::*;
  localparam int Q = 25;
  localparam logic [7:0] RI [13] = '{8'h00, 8'h01, 8'h02, 8'h03, 8'h04, 8'h05, 8'h06, 8'h07, 8'he0, 8'he1,
    8'he2, 8'he3, 8'he4};
  localparam logic [7:0] RE [13] = '{8'h1f, 8'h5c, 8'h00, 8'h01, 8'h5a, 8'hf1, 8'h00, 8'h00, 8'h00, 8'h80,
    8'hd7, 8'h00, 8'h00};
  logic clock, rst_b, psel, penable, pwrite, pready, pslverr, er, nak;
  logic [11:0] paddr;
  logic [31:0] pwdata, prdata, r;
  logic scl_o, scl_oe_b, sda_o, sda_oe_b, tb_scl, tb_sda, p_sda, mem_wr, mem_rd, mem_rdy;
  logic [23:0] mem_addr, wr_addr;
  logic [7:0] mem_wdata, wr_data, rd_byte, v;
  logic [7:0] mem_rdata = 8'h00;
  int err_total, compares;
  int cyc = 0, last_rise = 0, per = 0;
  // released lines read high through the pull-ups
  wire scl = scl_oe_b & tb_scl;
  wire sda = sda_oe_b & tb_sda & p_sda;
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    clock = 1'b0;
    forever #2.5 clock = ~clock;
  end
  twp_port twp_port_i (.clock(clock), .rst_b(rst_b), .ce(1'b1), .psel(psel), .penable(penable), .pwrite(pwrite),
    .paddr(paddr), .pwdata(pwdata), .prdata(prdata), .pready(pready), .pslverr(pslverr), .scl_i(scl),
    .scl_o(scl_o), .scl_oe_b(scl_oe_b), .sda_i(sda), .sda_o(sda_o), .sda_oe_b(sda_oe_b), .mem_addr(mem_addr),
    .mem_wdata(mem_wdata), .mem_wr(mem_wr), .mem_rd(mem_rd), .mem_rdata(mem_rdata), .mem_ready(mem_rdy));
  twp_target_model twp_target_model_i (.scl(scl), .sda(sda), .rd_byte(rd_byte), .sda_rel(p_sda));
  // memory: logs the last write, answers a read one cycle later
  always @(posedge clock)
  begin
    cyc <= cyc + 1;
    if (mem_wr === 1'b1)
    begin
      wr_addr <= mem_addr;
      wr_data <= mem_wdata;
    end
    if (mem_rd === 1'b1)
      mem_rdata <= mem_addr[7:0] ^ 8'h5a;
  end
  always @(posedge scl)
  begin
    per <= cyc - last_rise;
    last_rise <= cyc;
  end
  ////////////////////////////////////////////////////////////////////////////
  task automatic summarize();
    $display("compares=%0d err_total=%0d", compares, err_total);
    if (err_total == 0 && compares > 0)
      $display("verification passed");
    else
      $display("verification failed");
    $finish;
  endtask : summarize
  task automatic tmo();
    err_total++;
    $display("timeout at %0t", $time);
    summarize();
  endtask : tmo
  task automatic chk(input logic [31:0] seen, input logic [31:0] exp);
    compares++;
    if (seen !== exp)
    begin
      err_total++;
      $display("[ERR] t=%0t seen=%h exp=%h", $time, seen, exp);
    end
  endtask : chk
  task automatic apb(input logic w, input logic [7:0] idx, input logic [7:0] wd);
    int n;
    n = 0;
    psel <= 1'b1;
    penable <= 1'b0;
    pwrite <= w;
    paddr <= {2'b00, idx, 2'b00};
    pwdata <= {24'h00_0000, wd};
    @(posedge clock);
    penable <= 1'b1;
    @(posedge clock);
    while (pready !== 1'b1)
    begin
      n++;
      if (n > 50)
        tmo();
      @(posedge clock);
    end
    r = prdata;
    er = pslverr;
    psel <= 1'b0;
    penable <= 1'b0;
    @(posedge clock);
  endtask : apb
  task automatic wr(input logic [7:0] idx, input logic [7:0] d);
    apb(1'b1, idx, d);
  endtask : wr
  task automatic rdc(input logic [7:0] idx, input logic [7:0] e);
    apb(1'b0, idx, 8'h00);
    chk(r, {24'h00_0000, e});
  endtask : rdc
  task automatic wait_idle();
    int n;
    n = 0;
    apb(1'b0, IDX_STAT, 8'h00);
    while (r[1:0] !== 2'b00)
    begin
      n++;
      if (n > 2000)
        tmo();
      apb(1'b0, IDX_STAT, 8'h00);
    end
  endtask : wait_idle
  task automatic qtr(input logic c, input logic d);
    tb_scl <= c;
    tb_sda <= d;
    repeat (Q) @(posedge clock);
  endtask : qtr
  // bench initiator: sda moves only while scl is low, except in start and stop, which move it while scl is high
  task automatic bitx(input logic d, output logic s);
    qtr(1'b0, tb_sda);
    qtr(1'b0, d);
    qtr(1'b1, d);
    s = sda;
    qtr(1'b1, d);
  endtask : bitx
  task automatic start();
    qtr(1'b0, tb_sda);
    qtr(1'b0, 1'b1);
    qtr(1'b1, 1'b1);
    qtr(1'b1, 1'b0);
  endtask : start
  task automatic stop();
    qtr(1'b0, tb_sda);
    qtr(1'b0, 1'b0);
    qtr(1'b1, 1'b0);
    qtr(1'b1, 1'b1);
  endtask : stop
  task automatic tx(input logic [7:0] b);
    logic s;
    for (int i = 7; i >= 0; i--)
      bitx(b[i], s);
    bitx(1'b1, s);
    nak = nak | s;
  endtask : tx
  task automatic rx(input logic ack_b);
    logic s;
    for (int i = 7; i >= 0; i--)
    begin
      bitx(1'b1, s);
      v[i] = s;
    end
    bitx(ack_b, s);
  endtask : rx
  ////////////////////////////////////////////////////////////////////////////
  initial
  begin
    rst_b = 1'b0;
    psel = 1'b0;
    penable = 1'b0;
    pwrite = 1'b0;
    paddr = 12'h000;
    pwdata = 32'h0000_0000;
    mem_rdy = 1'b1;
    tb_scl = 1'b1;
    tb_sda = 1'b1;
    rd_byte = 8'h96;
    err_total = 0;
    compares = 0;
    repeat (3) @(posedge clock);
    rst_b <= 1'b1;
    @(posedge clock);
    chk(32'({scl, sda}), 32'h3);
    chk(32'({scl_o, sda_o}), 32'h0);
    for (int i = 0; i < 13; i++)
      rdc(RI[i], RE[i]);
    apb(1'b0, 8'h08, 8'h00);
    chk({r[30:0], er}, 32'h1);
    wr(IDX_MOFF, 8'h55);
    rdc(IDX_MOFF, 8'h00);
    $display("test registers done");
    wr(IDX_DIV, 8'h03);
    rdc(IDX_DIV, 8'h03);
    wr(IDX_CTL, 8'h03);
    wr(IDX_BUF1, 8'ha1);
    wr(IDX_BUF2, 8'h52);
    wr(IDX_BUF3, 8'hc3);
    wr(IDX_SEQ, 8'h3f);
    apb(1'b0, IDX_STAT, 8'h00);
    chk(32'(r[0]), 32'h1);
    wait_idle();
    chk(32'(r[2]), 32'h0);
    chk(32'(per >= 12 && per <= 15), 32'h1);
    chk(32'({scl, sda}), 32'h3);
    chk(32'(twp_target_model_i.got.size()), 32'h3);
    chk({8'h00, twp_target_model_i.got[0], twp_target_model_i.got[1], twp_target_model_i.got[2]},
      32'h00a1_52c3);
    twp_target_model_i.got.delete();
    wr(IDX_BUF1, 8'h0f);
    wr(IDX_BUF2, 8'hf0);
    wr(IDX_SEQ, 8'h37);
    wait_idle();
    chk(32'(twp_target_model_i.got.size()), 32'h2);
    chk({16'h0000, twp_target_model_i.got[0], twp_target_model_i.got[1]}, 32'h0000_0ff0);
    wr(IDX_ID, 8'h7e);
    wr(IDX_SEQ, 8'h31);
    wait_idle();
    chk(32'(r[2]), 32'h1);
    wr(IDX_ID, 8'h5c);
    $display("test initiator write done");
    wr(IDX_SEQ, 8'hf9);
    wait_idle();
    rdc(IDX_BUF3, 8'h96);
    chk(32'(twp_target_model_i.mack), 32'h0);
    rd_byte = 8'h69;
    wr(IDX_SEQ, 8'h79);
    wait_idle();
    rdc(IDX_BUF3, 8'h69);
    chk(32'(twp_target_model_i.mack), 32'h1);
    $display("test initiator read done");
    wr(IDX_CTL, 8'h01);
    wr(IDX_ID, 8'h90);
    nak = 1'b0;
    start();
    tx(8'h90);
    tx(8'h04);
    tx(8'h00);
    tx(8'hcc);
    tx(8'h3c);
    chk({wr_addr, wr_data}, 32'h8400_cc3c);
    tx(8'h3d);
    chk({wr_addr, wr_data}, 32'h8400_cd3d);
    start();
    tx(8'h91);
    rx(1'b1);
    stop();
    chk(32'(v), 32'h0000_0094);
    chk(32'(nak), 32'h0);
    rdc(IDX_HOST, 8'h03);
    wr(IDX_HOST, 8'h01);
    rdc(IDX_HOST, 8'h02);
    wr(IDX_HOST, 8'h02);
    rdc(IDX_HOST, 8'h00);
    $display("test target direct done");
    wr(IDX_CTL, 8'h05);
    start();
    tx(8'h90);
    tx(8'h11);
    chk({wr_addr, wr_data}, 32'h00d7_8011);
    tx(8'h22);
    chk({wr_addr, wr_data}, 32'h00d7_8122);
    stop();
    start();
    tx(8'h90);
    tx(8'h33);
    stop();
    chk({wr_addr, wr_data}, 32'h00d7_8033);
    start();
    tx(8'h91);
    rx(1'b1);
    stop();
    chk(32'(v), 32'h0000_009a);
    rdc(IDX_MOFF, 8'h40);
    wr(IDX_CTL, 8'h0d);
    mem_rdy <= 1'b0;
    start();
    qtr(1'b0, 1'b0);
    qtr(1'b1, 1'b0);
    chk(32'(scl), 32'h0);
    mem_rdy <= 1'b1;
    qtr(1'b1, 1'b0);
    chk(32'(scl), 32'h1);
    qtr(1'b1, 1'b1);
    chk(32'({nak, scl, sda}), 32'h3);
    $display("test target mapped done");
    summarize();
  end
endmodule : tb
